// ===== core/bpc_pkg.sv
// Constants shared by the bridge PWM current controller and its half-bridge driver.
// Assumes a single 125 MHz clock domain.
package bpc_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int PWM_PERIOD_NS = 40960;
  localparam int PWM_STEPS = 32;
  localparam int TICK_CYC_DEF = PWM_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);
  localparam int DEAD_NS = 100;
  localparam int DEAD_CYC_DEF = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int JITTER_PCT = 10;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REQ = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  localparam int CTRL_EN = 0;
  localparam int CTRL_SLOPE_LSB = 1;
  localparam int CTRL_SLOPE_MSB = 2;
  localparam int CTRL_DOUBLE = 3;
  localparam int CTRL_JITTER = 4;
  localparam int CTRL_RANGE = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

  localparam int MAG_W = 5;
  localparam int REQ_X_LSB = 0;
  localparam int REQ_X_DIR = 5;
  localparam int REQ_Y_LSB = 8;
  localparam int REQ_Y_DIR = 13;
  localparam logic [13:0] REQ_RST = 14'h0000;
  localparam logic [MAG_W-1:0] MAG_HALF = 5'h10;

  localparam int IRQ_TRIP = 0;
  localparam int IRQ_FAST = 1;
  localparam int IRQ_LIMIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  localparam logic [1:0] SLOPE_FASTEST = 2'h0;
  localparam logic [1:0] SLOPE_SLOWEST = 2'h3;

  localparam logic [1:0] HB_CMD_OFF = 2'h0;
  localparam logic [1:0] HB_CMD_HI = 2'h1;
  localparam logic [1:0] HB_CMD_LO = 2'h2;

  localparam logic [1:0] DECAY_FWD = 2'h0;
  localparam logic [1:0] DECAY_SLOW = 2'h1;
  localparam logic [1:0] DECAY_FAST = 2'h2;

  localparam logic [7:0] LFSR_SEED = 8'hA5;

endpackage : bpc_pkg

// ===== core/bpc_half_bridge.sv
// One half-bridge: interlocked high/low gate drive with dead time, short protection, active diode.
// Assumes sense inputs are already synchronised to clock.
`timescale 1ns/1ps
module bpc_half_bridge
  import bpc_pkg::*;
#(
  parameter int DEAD_CYC = DEAD_CYC_DEF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [1:0] cmd,
  input wire logic ovc,
  input wire logic desat,
  input wire logic rev_hi,
  input wire logic rev_lo,
  output logic gate_hi,
  output logic gate_lo,
  output logic cur_limit,
  output logic tripped
);

  typedef enum logic [1:0] {HB_OFF, HB_DEAD, HB_HI, HB_LO} bpc_hb_e;

  if (DEAD_CYC < 1 || DEAD_CYC > 255) begin : g_chk
    $error("DEAD_CYC out of range");
  end

  bpc_hb_e st_q;
  logic [7:0] dead_q;
  logic trip_q;
  logic lim_q;
  logic [1:0] target;

  // Desaturation latches off the switch until the bridge is disabled
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trip_q <= 1'b0;
    end else if (!enable) begin
      trip_q <= 1'b0;
    end else if (desat) begin
      trip_q <= 1'b1;
    end
  end

  // First stage of short protection: limit gate current while overcurrent persists
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lim_q <= 1'b0;
    end else begin
      lim_q <= enable & ovc;
    end
  end

  always_comb begin
    target = cmd;
    if (!enable || trip_q || desat) begin
      target = HB_CMD_OFF;
    end else if (cmd == HB_CMD_OFF && rev_hi) begin
      target = HB_CMD_HI;
    end else if (cmd == HB_CMD_OFF && rev_lo) begin
      target = HB_CMD_LO;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= HB_OFF;
      dead_q <= 8'h00;
    end else begin
      case (st_q)
        HB_HI: begin
          if (target != HB_CMD_HI) begin
            st_q <= HB_DEAD;
            dead_q <= 8'h00;
          end
        end
        HB_LO: begin
          if (target != HB_CMD_LO) begin
            st_q <= HB_DEAD;
            dead_q <= 8'h00;
          end
        end
        HB_DEAD: begin
          dead_q <= dead_q + 8'h01;
          if (dead_q == 8'(DEAD_CYC - 1)) begin
            st_q <= HB_OFF;
          end
        end
        HB_OFF: begin
          if (target == HB_CMD_HI) begin
            st_q <= HB_HI;
          end else if (target == HB_CMD_LO) begin
            st_q <= HB_LO;
          end
        end
        default: st_q <= HB_OFF;
      endcase
    end
  end

  assign gate_hi = (st_q == HB_HI);
  assign gate_lo = (st_q == HB_LO);
  assign cur_limit = lim_q;
  assign tripped = trip_q;

  // Cycles since both gates went low, saturating
  logic [7:0] idle_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idle_q <= 8'hFF;
    end else if (gate_hi || gate_lo) begin
      idle_q <= 8'h00;
    end else if (idle_q != 8'hFF) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  property p_interlock;
    @(posedge clock) disable iff (!reset_n) !(gate_hi && gate_lo);
  endproperty
  a_interlock: assert property (p_interlock) else $error("both switches of a half-bridge on");

  property p_dead_gap;
    @(posedge clock) disable iff (!reset_n)
      ($rose(gate_hi) || $rose(gate_lo)) && $past(idle_q) != 8'hFF |-> $past(idle_q) >= 8'(DEAD_CYC);
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("dead interval too short");

  property p_desat_off;
    @(posedge clock) disable iff (!reset_n) desat |=> !gate_hi && !gate_lo;
  endproperty
  a_desat_off: assert property (p_desat_off) else $error("switch stays on after desaturation");

  property p_limit;
    @(posedge clock) disable iff (!reset_n) enable && ovc |=> cur_limit;
  endproperty
  a_limit: assert property (p_limit) else $error("current limit not applied");

  property p_active_diode;
    @(posedge clock) disable iff (!reset_n)
      st_q == HB_OFF && enable && !trip_q && !desat && cmd == HB_CMD_OFF && rev_lo && !rev_hi |=> gate_lo;
  endproperty
  a_active_diode: assert property (p_active_diode) else $error("reverse current switch not turned on");

endmodule : bpc_half_bridge

// ===== core/bpc_bridge_ctrl.sv
// Dual full-bridge PWM current regulator with register port, interrupt and short protection.
// Assumes comparator and sense inputs are asynchronous pins; registers are reached over a plain port.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module bpc_bridge_ctrl
  import bpc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter int DEAD_CYC = DEAD_CYC_DEF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [1:0] cur_above_req,
  input wire logic [3:0] short_ovc,
  input wire logic [3:0] short_desat,
  input wire logic [3:0] rev_hi,
  input wire logic [3:0] rev_lo,
  output logic [3:0] gate_hi,
  output logic [3:0] gate_lo,
  output logic [3:0] cur_limit,
  output logic [1:0] slope_select,
  output logic [3:0] ls_rdson_sel,
  output logic [4:0] req_mag_x,
  output logic [4:0] req_mag_y,
  output logic irq
);

  typedef enum logic [1:0] {DM_FWD, DM_SLOW, DM_FAST} bpc_decay_e;

  if (TICK_CYC < 20 || TICK_CYC > 16383) begin : g_chk
    $error("TICK_CYC out of range");
  end

  // Half-bridge command for one coil: {B, A}
  function automatic logic [3:0] coil_cmd(input bpc_decay_e m, input logic dir);
    logic [1:0] fwd_a;
    logic [1:0] fwd_b;
    fwd_a = dir ? HB_CMD_LO : HB_CMD_HI;
    fwd_b = dir ? HB_CMD_HI : HB_CMD_LO;
    case (m)
      DM_FWD: coil_cmd = {fwd_b, fwd_a};
      DM_SLOW: coil_cmd = {HB_CMD_LO, HB_CMD_LO};
      DM_FAST: coil_cmd = {fwd_a, fwd_b};
      default: coil_cmd = {HB_CMD_OFF, HB_CMD_OFF};
    endcase
  endfunction : coil_cmd

  // Two-stage synchronisers for all analogue-side sense pins
  localparam int SYNC_W = 18;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {rev_lo, rev_hi, short_desat, short_ovc, cur_above_req};
      sync2_q <= sync1_q;
    end
  end
  logic [1:0] cmp_s;
  logic [3:0] ovc_s;
  logic [3:0] desat_s;
  logic [3:0] rev_hi_s;
  logic [3:0] rev_lo_s;
  assign cmp_s = sync2_q[1:0];
  assign ovc_s = sync2_q[5:2];
  assign desat_s = sync2_q[9:6];
  assign rev_hi_s = sync2_q[13:10];
  assign rev_lo_s = sync2_q[17:14];

  // Register file
  logic [CTRL_W-1:0] ctrl_q;
  logic [13:0] req_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  logic en_q;
  logic wr_ctrl;
  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  assign en_q = ctrl_q[CTRL_EN];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= REQ_RST;
    end else if (reg_wr && reg_addr == ADDR_REQ) begin
      req_q <= reg_wdata[13:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_q <= IRQ_RST;
    end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      irq_mask_q <= reg_wdata[IRQ_W-1:0];
    end
  end

  // Sticky status: a new event wins over a same-cycle write-one clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == ADDR_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : IRQ_RST))
                    | irq_ev;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  logic [3:0] mode_vec;
  logic [3:0] trip_vec;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= {26'h0, ctrl_q};
        ADDR_REQ: reg_rdata <= {18'h0, req_q};
        ADDR_STATE: reg_rdata <= {20'h0, cur_limit, trip_vec, mode_vec};
        ADDR_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_q};
        ADDR_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Internal PWM clock: tick length from the system clock and settings only
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_len_q;
  logic [15:0] tick_len_d;
  logic [7:0] lfsr_q;
  logic [4:0] phase_q;
  logic tick;
  logic period_start;
  int base;
  int depth;

  assign tick = tick_cnt_q == tick_len_q - 16'h0001;
  assign period_start = tick && phase_q == 5'(PWM_STEPS - 1);

  always_comb begin
    base = ctrl_q[CTRL_DOUBLE] ? TICK_CYC / 2 : TICK_CYC;
    depth = base * JITTER_PCT / 100;
    if (ctrl_q[CTRL_JITTER]) begin
      tick_len_d = 16'(base - depth / 2 + ((int'(lfsr_q) * (depth / 2 * 2 + 1)) >> 8));
    end else begin
      tick_len_d = 16'(base);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 16'h0000;
      tick_len_q <= 16'(TICK_CYC);
      phase_q <= 5'h00;
      lfsr_q <= LFSR_SEED;
    end else if (tick) begin
      tick_cnt_q <= 16'h0000;
      tick_len_q <= tick_len_d;
      phase_q <= phase_q + 5'h01;
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // Per-coil regulator
  logic [1:0] fast_entry;
  logic [1:0] pend_vec;
  logic [7:0] hb_cmd;
  logic [MAG_W-1:0] mag [2];
  logic [1:0] dir;
  assign mag[0] = req_q[REQ_X_LSB +: MAG_W];
  assign mag[1] = req_q[REQ_Y_LSB +: MAG_W];
  assign dir = {req_q[REQ_Y_DIR], req_q[REQ_X_DIR]};

  for (genvar c = 0; c < 2; c++) begin : g_coil
    bpc_decay_e mode_q;
    logic [MAG_W-1:0] prev_q;
    logic pend_q;
    logic drop;
    assign drop = mag[c] < prev_q;

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        prev_q <= '0;
      end else begin
        prev_q <= mag[c];
      end
    end

    // Pending step-down; a new drop wins over consumption on the same tick
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        pend_q <= 1'b0;
      end else if (drop) begin
        pend_q <= 1'b1;
      end else if (tick && mode_q != DM_FAST) begin
        pend_q <= 1'b0;
      end
    end

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        mode_q <= DM_SLOW;
      end else if (tick) begin
        case (mode_q)
          DM_FAST: begin
            if (!cmp_s[c]) begin
              mode_q <= period_start ? DM_FWD : DM_SLOW;
            end
          end
          DM_FWD, DM_SLOW: begin
            if (pend_q && cmp_s[c]) begin
              mode_q <= DM_FAST;
            end else if (period_start) begin
              mode_q <= DM_FWD;
            end else if (mode_q == DM_FWD && cmp_s[c]) begin
              mode_q <= DM_SLOW;
            end
          end
          default: mode_q <= DM_SLOW;
        endcase
      end
    end

    assign fast_entry[c] = tick && mode_q != DM_FAST && pend_q && cmp_s[c];
    assign pend_vec[c] = pend_q;
    assign mode_vec[2*c +: 2] = mode_q;
    assign hb_cmd[4*c +: 4] = (mag[c] == '0) ? {HB_CMD_OFF, HB_CMD_OFF} : coil_cmd(mode_q, dir[c]);

    // Low side sized from range and request level
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        ls_rdson_sel[2*c +: 2] <= 2'h0;
      end else begin
        ls_rdson_sel[2*c +: 2] <= {ctrl_q[CTRL_RANGE], mag[c] >= MAG_HALF};
      end
    end
  end

  for (genvar h = 0; h < 4; h++) begin : g_hb
    bpc_half_bridge #(
      .DEAD_CYC(DEAD_CYC)
    ) u_hb (
      .clock(clock),
      .reset_n(reset_n),
      .enable(en_q),
      .cmd(hb_cmd[2*h +: 2]),
      .ovc(ovc_s[h]),
      .desat(desat_s[h]),
      .rev_hi(rev_hi_s[h]),
      .rev_lo(rev_lo_s[h]),
      .gate_hi(gate_hi[h]),
      .gate_lo(gate_lo[h]),
      .cur_limit(cur_limit[h]),
      .tripped(trip_vec[h])
    );
  end

  logic [3:0] trip_prev_q;
  logic [3:0] lim_prev_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trip_prev_q <= 4'h0;
      lim_prev_q <= 4'h0;
    end else begin
      trip_prev_q <= trip_vec;
      lim_prev_q <= cur_limit;
    end
  end

  assign irq_ev[IRQ_TRIP] = |(trip_vec & ~trip_prev_q);
  assign irq_ev[IRQ_FAST] = |fast_entry;
  assign irq_ev[IRQ_LIMIT] = |(cur_limit & ~lim_prev_q);

  assign slope_select = ctrl_q[CTRL_SLOPE_MSB:CTRL_SLOPE_LSB];
  assign req_mag_x = mag[0];
  assign req_mag_y = mag[1];

  // Assertions
  property p_disable_off;
    @(posedge clock) disable iff (!reset_n) !en_q |=> gate_hi == 4'h0 && gate_lo == 4'h0;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("bridge switch on while disabled");

  sequence s_enable_wr;
    wr_ctrl && reg_wdata[CTRL_EN] && !short_desat[0] && !short_ovc[0];
  endsequence
  property p_enable_drive;
    @(posedge clock) disable iff (!reset_n)
      s_enable_wr ##1 (en_q && hb_cmd[1:0] == HB_CMD_LO && sync2_q[9:6] == 4'h0 && gate_hi[0] == 1'b0) [*3]
      |=> gate_lo[0] || $past(gate_lo[0]) || hb_cmd[1:0] != HB_CMD_LO;
  endproperty
  a_enable_drive: assert property (p_enable_drive) else $error("bridge not driven after enable");

  property p_slope_wr;
    @(posedge clock) disable iff (!reset_n)
      wr_ctrl |=> slope_select == $past(reg_wdata[CTRL_SLOPE_MSB:CTRL_SLOPE_LSB]);
  endproperty
  a_slope_wr: assert property (p_slope_wr) else $error("slope select not applied");

  property p_mode_on_tick;
    @(posedge clock) disable iff (!reset_n) $changed(mode_vec) |-> $past(tick);
  endproperty
  a_mode_on_tick: assert property (p_mode_on_tick) else $error("switching point off the PWM clock");

  property p_double;
    @(posedge clock) disable iff (!reset_n)
      tick && ctrl_q[CTRL_DOUBLE] && !ctrl_q[CTRL_JITTER] |=> tick_len_q == 16'(TICK_CYC / 2);
  endproperty
  a_double: assert property (p_double) else $error("doubled PWM frequency wrong");

  property p_jitter_depth;
    @(posedge clock) disable iff (!reset_n)
      tick && ctrl_q[CTRL_JITTER] |=> int'(tick_len_q) >= $past(base) - $past(depth) / 2
                                     && int'(tick_len_q) <= $past(base) + $past(depth) / 2;
  endproperty
  a_jitter_depth: assert property (p_jitter_depth) else $error("jitter outside depth");

  property p_fast_cause;
    @(posedge clock) disable iff (!reset_n) $rose(mode_vec[1:0] == DECAY_FAST) |-> $past(pend_vec[0]);
  endproperty
  a_fast_cause: assert property (p_fast_cause) else $error("fast decay without step-down");

  property p_fast_exit;
    @(posedge clock) disable iff (!reset_n)
      tick && mode_vec[1:0] == DECAY_FAST && !cmp_s[0] |=> mode_vec[1:0] != DECAY_FAST;
  endproperty
  a_fast_exit: assert property (p_fast_exit) else $error("fast decay held past the request");

  property p_ls_size;
    @(posedge clock) disable iff (!reset_n)
      ##1 ls_rdson_sel[1:0] == {$past(ctrl_q[CTRL_RANGE]), $past(req_q[REQ_X_LSB +: MAG_W]) >= MAG_HALF};
  endproperty
  a_ls_size: assert property (p_ls_size) else $error("low-side resistance selection wrong");

endmodule : bpc_bridge_ctrl

// ===== testbench/bpc_winding_model.sv
// Winding pair model: current magnitude per coil and the comparator against the request.
// Assumes coils run in direction 0; half-bridges 2c and 2c+1 form coil c.
`timescale 1ns/1ps
module bpc_winding_model (
  input wire logic clock,
  input wire logic [3:0] gate_hi,
  input wire logic [3:0] gate_lo,
  input wire logic [4:0] req_mag_x,
  input wire logic [4:0] req_mag_y,
  output logic [1:0] cur_above_req
);
  int cur_q [2];
  int tick_q = 0;
  // Forward rises fast, fast decay falls fast, slow decay leaks slowly
  always_ff @(posedge clock) begin
    tick_q <= tick_q + 1;
    for (int c = 0; c < 2; c++) begin
      if (gate_hi[2*c] && gate_lo[2*c+1])
        cur_q[c] <= cur_q[c] + 1;
      else if (gate_hi[2*c+1] && gate_lo[2*c])
        cur_q[c] <= (cur_q[c] > 4) ? cur_q[c] - 4 : 0;
      else if (tick_q % 8 == 0 && cur_q[c] > 0)
        cur_q[c] <= cur_q[c] - 1;
    end
  end
  assign cur_above_req = {cur_q[1] > 8 * req_mag_y, cur_q[0] > 8 * req_mag_x};
endmodule : bpc_winding_model

// ===== testbench/testbench.sv
// Self-checking bench for the dual bridge current regulator, driven through its register port.
// Assumes shortened tick and dead-time parameters and the winding model on the gate side.
`timescale 1ns/1ps
module testbench;
  import bpc_pkg::*;
  localparam int TICK = 20;
  localparam int DEAD = 2;
  localparam int PER = 32 * TICK;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] req;
    logic [1:0] slope;
    logic [3:0] ls;
  } bpc_row_s;
  bpc_row_s rows [5] = '{'{32'h00, 32'h0000, 2'h0, 4'h0}, '{32'h02, 32'h0010, 2'h1, 4'h1},
    '{32'h04, 32'h1000, 2'h2, 4'h4}, '{32'h26, 32'h1F0F, 2'h3, 4'hE}, '{32'h18, 32'h2025, 2'h0, 4'h0}};
  logic [7:0] raddr [6] = '{ADDR_CTRL, ADDR_REQ, ADDR_STATE, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h14};
  logic [31:0] rexp [6] = '{32'h0, 32'h0, 32'h5, 32'h0, 32'h0, 32'h0};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] short_ovc = 4'h0;
  logic [3:0] short_desat = 4'h0;
  logic [3:0] rev_hi = 4'h0;
  logic [3:0] rev_lo = 4'h0;
  logic [31:0] reg_rdata, rd;
  logic [1:0] cur_above_req, slope_select;
  logic [3:0] gate_hi, gate_lo, cur_limit, ls_rdson_sel;
  logic [3:0] hi_p = 4'h0;
  logic [3:0] lo_p = 4'h0;
  logic [4:0] req_mag_x, req_mag_y;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;
  int bad = 0;
  int cyc = 0;
  int last_rise = 0;
  int period = 0;
  int rises = 0;
  int fast_seen = 0;
  int off_cnt [4];

  bpc_bridge_ctrl #(.TICK_CYC(TICK), .DEAD_CYC(DEAD)) u_bpc_bridge_ctrl (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cur_above_req(cur_above_req), .short_ovc(short_ovc), .short_desat(short_desat), .rev_hi(rev_hi),
    .rev_lo(rev_lo), .gate_hi(gate_hi), .gate_lo(gate_lo), .cur_limit(cur_limit), .slope_select(slope_select),
    .ls_rdson_sel(ls_rdson_sel), .req_mag_x(req_mag_x), .req_mag_y(req_mag_y), .irq(irq));
  bpc_winding_model u_bpc_winding_model (.clock(clock), .gate_hi(gate_hi), .gate_lo(gate_lo),
    .req_mag_x(req_mag_x), .req_mag_y(req_mag_y), .cur_above_req(cur_above_req));

  initial begin
    forever #4 clock = ~clock;
  end

  // Interlock, dead interval, fast decay and PWM period watch on the gates
  always @(posedge clock) begin
    cyc++;
    for (int h = 0; h < 4; h++) begin
      if (gate_hi[h] && gate_lo[h]) bad++;
      if ((gate_hi[h] && lo_p[h]) || (gate_lo[h] && hi_p[h])) bad++;
      if ((gate_hi[h] || gate_lo[h]) && !hi_p[h] && !lo_p[h] && off_cnt[h] < DEAD) bad++;
      off_cnt[h] = (gate_hi[h] || gate_lo[h]) ? 0 : off_cnt[h] + 1;
    end
    if (gate_hi[1] && gate_lo[0]) fast_seen = 1;
    if (gate_hi[0] && !hi_p[0]) begin
      period = cyc - last_rise;
      last_rise = cyc;
      rises++;
    end
    hi_p = gate_hi;
    lo_p = gate_lo;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic check_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : check_reg

  task automatic check_pin(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED pin %s expected %h seen %h", n, e, g);
    end
  endtask : check_pin

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : rdreg

  task automatic wait_rises(input int n);
    int start;
    start = rises;
    for (int i = 0; i < 4 * n * PER && rises < start + n; i++) @(posedge clock);
    if (rises < start + n) begin
      mismatches++;
      close_out();
    end
  endtask : wait_rises

  initial begin
    #800000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    check_pin("gates after reset", 32'h0, {gate_hi, gate_lo, cur_limit, 1'b0, irq});
    for (int i = 0; i < 6; i++) begin
      rdreg(raddr[i]);
      check_reg("reset value", rexp[i], rd);
    end
    foreach (rows[i]) begin
      wr(ADDR_CTRL, rows[i].ctrl);
      wr(ADDR_REQ, rows[i].req);
      rdreg(ADDR_CTRL);
      check_reg("ctrl", rows[i].ctrl, rd);
      rdreg(ADDR_REQ);
      check_reg("req", rows[i].req, rd);
      check_pin("slope", 32'(rows[i].slope), 32'(slope_select));
      check_pin("low side size", 32'(rows[i].ls), 32'(ls_rdson_sel));
      check_pin("mags", {rows[i].req[12:8], rows[i].req[4:0]}, {req_mag_y, req_mag_x});
    end
    wr(ADDR_REQ, 32'h0808);
    wr(ADDR_CTRL, 32'h01);
    wait_rises(3);
    fast_seen = 0;
    wait_rises(3);
    check_pin("steady fast", 32'h0, fast_seen);
    check_pin("period", PER, period);
    wr(ADDR_CTRL, 32'h09);
    wait_rises(3);
    check_pin("double period", PER / 2, period);
    wr(ADDR_CTRL, 32'h11);
    wait_rises(3);
    check_pin("jitter", 32'h1, 32'(period >= PER * 19 / 20 && period <= PER * 21 / 20));
    wr(ADDR_CTRL, 32'h01);
    wr(ADDR_REQ, 32'h0818);
    wr(ADDR_IRQ_MASK, 32'h2);
    wait_rises(3);
    wr(ADDR_IRQ_STAT, 32'h7);
    fast_seen = 0;
    wr(ADDR_REQ, 32'h0802);
    wait_rises(1);
    check_pin("fast on step down", 32'h1, fast_seen);
    rdreg(ADDR_IRQ_STAT);
    check_reg("irq stat fast", 32'h2, rd);
    check_pin("irq", 32'h1, 32'(irq));
    wr(ADDR_IRQ_STAT, 32'h2);
    #1;
    check_pin("irq cleared", 32'h0, 32'(irq));
    wait_rises(3);
    rdreg(ADDR_STATE);
    check_reg("fast ended", 32'h1, 32'(rd[1:0] !== DECAY_FAST));
    short_ovc <= 4'h1;
    repeat (4) @(posedge clock);
    #1;
    check_pin("current limit", 32'h1, 32'(cur_limit));
    short_desat <= 4'h1;
    repeat (4) @(posedge clock);
    #1;
    check_pin("desat off", 32'h0, {gate_hi[0], gate_lo[0]});
    short_ovc <= 4'h0;
    short_desat <= 4'h0;
    repeat (PER) @(posedge clock);
    #1;
    check_pin("trip holds", 32'h0, {gate_hi[0], gate_lo[0]});
    rdreg(ADDR_IRQ_STAT);
    check_reg("irq stat short", 32'h5, rd & 32'h5);
    check_pin("irq masked", 32'h0, 32'(irq));
    wr(ADDR_CTRL, 32'h00);
    repeat (2) @(posedge clock);
    #1;
    check_pin("disabled", 32'h0, {gate_hi, gate_lo});
    wr(ADDR_CTRL, 32'h01);
    wait_rises(1);
    check_pin("coil y on", 32'h1, 32'((gate_hi[3:2] | gate_lo[3:2]) != 2'h0));
    wr(ADDR_REQ, 32'h0002);
    repeat (8) @(posedge clock);
    #1;
    check_pin("coil y released", 32'h0, {gate_hi[3:2], gate_lo[3:2]});
    @(posedge clock);
    rev_lo <= 4'h4;
    rev_hi <= 4'h8;
    repeat (4) @(posedge clock);
    #1;
    check_pin("active diodes", 32'h9, {gate_hi[3:2], gate_lo[3:2]});
    check_pin("gate overlap", 32'h0, bad);
    close_out();
  end
endmodule : testbench
